// [include/stoc_defines.vh]
`ifndef STOC_DEFINES_VH
`define STOC_DEFINES_VH

// ****************************************
// Timer state codes
// ****************************************
`define STOC_ST_CLEARED   3'h0
`define STOC_ST_RUNNING   3'h1
`define STOC_ST_HALTED    3'h2
`define STOC_ST_RESTART   3'h3
`define STOC_ST_COMPLETE  3'h4

// ****************************************
// Trigger field: bit 3 inverts, bits 2:0 name a state
// ****************************************
`define STOC_TRIG_INV_BIT 3
`define STOC_TRIG_RST     4'h0

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define STOC_REG_STAT_CFG  4'h0
`define STOC_REG_STAT_DLY  4'h4
`define STOC_REG_CTL1_CFG  4'h8
`define STOC_REG_CTL1_DLY  4'hC
`define STOC_REG_STATUS    4'h2

// ****************************************
// Config fields: [0] enable, [7:4] on trig, [11:8] off trig
// ****************************************
`define STOC_CFG_EN_BIT    0
`define STOC_CFG_ON_LSB    4
`define STOC_CFG_OFF_LSB   8

// ****************************************
// Timing
// ****************************************
`define STOC_CLK_HZ        200000000
`define STOC_DLY_MAX_S     32400
`define STOC_DLY_RST       16'h0000

`endif

// [rtl/stoc_output_chan.v]
`timescale 1ns/10ps
`include "stoc_defines.vh"

module stoc_output_chan #(
    parameter TICKS_PER_S = `STOC_CLK_HZ
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Timer state entry
    input  wire        enter,
    input  wire [2:0]  state,
    // Settings
    input  wire        enable,
    input  wire [3:0]  on_trig,
    input  wire [3:0]  off_trig,
    input  wire [15:0] on_delay,
    // Result
    output reg         out_r,
    output reg         pending_r
);

    reg  [31:0] tick_r;
    reg  [15:0] secs_r;
    wire        on_hit;
    wire        off_hit;

    // Inverted form matches any state other than the named one.
    assign on_hit  = enter & ((on_trig[2:0] == state) ^ on_trig[`STOC_TRIG_INV_BIT]);
    assign off_hit = enter & ((off_trig[2:0] == state) ^ off_trig[`STOC_TRIG_INV_BIT]);

    // ****************************************
    // Edge-set, edge-cleared output
    // ****************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_r     <= 1'b0;
            pending_r <= 1'b0;
            tick_r    <= 32'h00000000;
            secs_r    <= 16'h0000;
        end else if (!enable) begin
            // Settings are left alone; only the output state is dropped.
            out_r     <= 1'b0;
            pending_r <= 1'b0;
        end else if (off_hit) begin
            out_r     <= 1'b0;
            pending_r <= 1'b0;
        end else if (on_hit) begin
            if (on_delay == 16'h0000) begin
                out_r <= 1'b1;
            end else begin
                pending_r <= 1'b1;
                tick_r    <= 32'h00000000;
                secs_r    <= 16'h0000;
            end
        end else if (pending_r) begin
            if (tick_r == TICKS_PER_S - 1) begin
                tick_r <= 32'h00000000;
                if (secs_r + 16'h0001 >= on_delay) begin
                    out_r     <= 1'b1;
                    pending_r <= 1'b0;
                end
                secs_r <= secs_r + 16'h0001;
            end else begin
                tick_r <= tick_r + 32'h00000001;
            end
        end
        // Otherwise the output holds across other state changes.
    end

endmodule

// [rtl/stoc_top.v]
`timescale 1ns/10ps
`include "stoc_defines.vh"

module stoc_top #(
    parameter TICKS_PER_S = `STOC_CLK_HZ
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Timer core state
    input  wire [2:0]  timer_state,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Outputs and annunciators
    output wire        status_out,
    output wire        ctrl1_out,
    output wire        status_lamp,
    output wire        ctrl1_lamp
);

    reg  [11:0] stat_cfg_r;
    reg  [15:0] status_on_delay_r;
    reg  [11:0] ctl1_cfg_r;
    reg  [15:0] ctrl1_on_delay_r;
    reg  [2:0]  prev_state_r;
    reg         started_r;
    wire        enter;
    wire        stat_pend;
    wire        ctl1_pend;
    wire        wb_req;
    wire [31:0] rd_nxt;

    // ****************************************
    // State entry detection
    // ****************************************
    // The first sample after reset counts as entering the current state.
    assign enter = !started_r || (timer_state != prev_state_r);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_state_r <= `STOC_ST_CLEARED;
            started_r    <= 1'b0;
        end else begin
            prev_state_r <= timer_state;
            started_r    <= 1'b1;
        end
    end

    // ****************************************
    // Wishbone register file
    // ****************************************
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_cfg_r        <= 12'h000;
            status_on_delay_r <= `STOC_DLY_RST;
            ctl1_cfg_r        <= 12'h000;
            ctrl1_on_delay_r  <= `STOC_DLY_RST;
        end else if (wb_req && wb_we_i && wb_adr_i[3]) begin
            // Upper word bank: control output 1.
            if (wb_adr_i == `STOC_REG_CTL1_CFG) begin
                if (wb_sel_i[0]) ctl1_cfg_r[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ctl1_cfg_r[11:8] <= wb_dat_i[11:8];
            end else if (wb_adr_i == `STOC_REG_CTL1_DLY) begin
                if (wb_sel_i[0]) ctrl1_on_delay_r[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ctrl1_on_delay_r[15:8] <= wb_dat_i[15:8];
            end
        end else if (wb_req && wb_we_i) begin
            if (wb_adr_i == `STOC_REG_STAT_CFG) begin
                if (wb_sel_i[0]) stat_cfg_r[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) stat_cfg_r[11:8] <= wb_dat_i[11:8];
            end else if (wb_adr_i == `STOC_REG_STAT_DLY) begin
                if (wb_sel_i[0]) status_on_delay_r[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) status_on_delay_r[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // Reads: offsets 0/4/8/C return settings and the status offset returns live state.
    // Every other offset reads zero so software can probe the map safely.
    assign rd_nxt =
        (wb_adr_i == `STOC_REG_STAT_CFG) ? {20'h00000, stat_cfg_r} :
        (wb_adr_i == `STOC_REG_STAT_DLY) ? {16'h0000, status_on_delay_r} :
        (wb_adr_i == `STOC_REG_CTL1_CFG) ? {20'h00000, ctl1_cfg_r} :
        (wb_adr_i == `STOC_REG_CTL1_DLY) ? {16'h0000, ctrl1_on_delay_r} :
        (wb_adr_i == `STOC_REG_STATUS) ? {25'h0000000, prev_state_r, ctl1_pend, stat_pend,
                              ctrl1_out, status_out} :
        32'h00000000;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // ****************************************
    // Output channels
    // ****************************************
    stoc_output_chan #(
        .TICKS_PER_S (TICKS_PER_S)
    ) u_status (
        .clk       (clk),
        .reset_n   (reset_n),
        .enter     (enter),
        .state     (timer_state),
        .enable    (stat_cfg_r[`STOC_CFG_EN_BIT]),
        .on_trig   (stat_cfg_r[7:4]),
        .off_trig  (stat_cfg_r[11:8]),
        .on_delay  (status_on_delay_r),
        .out_r     (status_out),
        .pending_r (stat_pend)
    );

    // Control output 1 reuses the identical channel logic.
    stoc_output_chan #(
        .TICKS_PER_S (TICKS_PER_S)
    ) u_ctrl1 (
        .clk       (clk),
        .reset_n   (reset_n),
        .enter     (enter),
        .state     (timer_state),
        .enable    (ctl1_cfg_r[`STOC_CFG_EN_BIT]),
        .on_trig   (ctl1_cfg_r[7:4]),
        .off_trig  (ctl1_cfg_r[11:8]),
        .on_delay  (ctrl1_on_delay_r),
        .out_r     (ctrl1_out),
        .pending_r (ctl1_pend)
    );

    assign status_lamp = status_out;
    assign ctrl1_lamp  = ctrl1_out;

endmodule

// [verification/stoc_props.sv]
`timescale 1ns/10ps
module stoc_props (
    input wire        clk,
    input wire        reset_n,
    input wire [2:0]  timer_state,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        status_out,
    input wire        ctrl1_out,
    input wire        status_lamp,
    input wire        ctrl1_lamp
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Shadow enables, so a disabled output can be held to zero.
    reg  st_en_r;
    reg  c1_en_r;
    wire wr_cfg = wb_ack_o && wb_we_i && wb_sel_i[0];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_en_r <= 1'b0;
            c1_en_r <= 1'b0;
        end else if (wr_cfg && wb_adr_i == 4'h0) begin
            st_en_r <= wb_dat_i[0];
        end else if (wr_cfg && wb_adr_i == 4'h8) begin
            c1_en_r <= wb_dat_i[0];
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_st_lamp; status_lamp == status_out; endproperty
    property p_c1_lamp; ctrl1_lamp == ctrl1_out; endproperty
    property p_ack; s_req |=> s_ans; endproperty
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_st_dis; !st_en_r |=> !status_out; endproperty
    property p_c1_dis; !c1_en_r |=> !ctrl1_out; endproperty
    property p_st_fall;
        $fell(status_out) |-> $past(timer_state, 1) != $past(timer_state, 2) || !st_en_r;
    endproperty
    property p_c1_fall;
        $fell(ctrl1_out) |-> $past(timer_state, 1) != $past(timer_state, 2) || !c1_en_r;
    endproperty
    a_st_lamp: assert property (p_st_lamp) else $error("status lamp differs");
    a_c1_lamp: assert property (p_c1_lamp) else $error("ctrl1 lamp differs");
    a_ack: assert property (p_ack) else $error("ack missing or long");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_st_dis: assert property (p_st_dis) else $error("disabled status on");
    a_c1_dis: assert property (p_c1_dis) else $error("disabled ctrl1 on");
    a_st_fall: assert property (p_st_fall) else $error("status fell idle");
    a_c1_fall: assert property (p_c1_fall) else $error("ctrl1 fell idle");
endmodule
bind stoc_top stoc_props u_props (.*);

// [verification/stoc_load.sv]
`timescale 1ns/10ps
// A load counting closures; a real load only sees the switch level.
module stoc_load (
    input  wire       clk,
    input  wire       sw_in,
    output reg  [7:0] closures
);
    reg last_r;
    initial closures = 8'h00;
    initial last_r = 1'b0;
    always @(posedge clk) begin
        last_r <= sw_in;
        if (sw_in && !last_r) closures <= closures + 8'h01;
    end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    reg clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
    reg  [2:0]  ts = 0;
    reg  [3:0]  adr = 0;
    reg  [31:0] wd = 0;
    wire [31:0] rdat;
    wire ack, so, co, sl, cl;
    wire [7:0] nclose;
    int fail_count = 0, compares = 0, c;
    stoc_top #(.TICKS_PER_S(4)) DUT (.clk(clk), .reset_n(reset_n), .timer_state(ts),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .status_out(so), .ctrl1_out(co),
        .status_lamp(sl), .ctrl1_lamp(cl));
    stoc_load u_load (.clk(clk), .sw_in(so), .closures(nclose));
    initial forever #2.5 clk = ~clk;
    task stop_test;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(string n, logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task bus(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task wr(logic [3:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task rd(logic [3:0] a, logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk("rdata", r, e);
    endtask
    function logic outp();
        return c ? co : so;
    endfunction
    task go(logic [2:0] s, logic e);
        @(posedge clk);
        ts <= s;
        repeat (2) @(posedge clk);
        #1 chk("out", outp(), e);
        chk("lamp", c ? cl : sl, e);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h0);
        for (c = 0; c < 2; c++) begin
            wr(c * 8, 32'h411);
            go(1, 1);
            go(2, 1);
            go(4, 0);
            wr(c * 8, 32'h911);
            go(1, 1);
            go(2, 0);
            wr(c * 8, 32'h081);
            go(3, 1);
            go(0, 0);
            wr(c * 8, 32'h221);
            go(2, 0);
            wr(c * 8, 32'h411);
            go(1, 1);
            wr(c * 8, 32'h410);
            repeat (2) @(posedge clk);
            #1 chk("disabled", outp(), 0);
            rd(c * 8, 32'h410);
            wr(c * 8 + 4, 32'h2);
            wr(c * 8, 32'h411);
            go(4, 0);
            go(1, 0);
            rd(4'h2, c ? 32'h19 : 32'h14);
            repeat (10) @(posedge clk);
            #1 chk("delayed", outp(), 1);
            go(4, 0);
            go(1, 0);
            go(4, 0);
            repeat (12) @(posedge clk);
            #1 chk("cancel", outp(), 0);
            wr(c * 8 + 4, 32'h0);
            $display("channel %0d done", c);
        end
        chk("closures", nclose, 32'h9);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule
